// ==== hw/efm_params.svh ====
// Constants of the encoder fault monitor: offsets, fields, resets, timing.
// Assumes a 10 MHz module clock; included by bare name.
`ifndef EFM_PARAMS_SVH
`define EFM_PARAMS_SVH

// Module clock rate in MHz
`define EFM_CLK_MHZ       10

// Register byte offsets
`define EFM_REG_CTRL      8'h00
`define EFM_REG_SSICFG    8'h04
`define EFM_REG_INCREV    8'h08
`define EFM_REG_POS       8'h0C
`define EFM_REG_STAT      8'h10
`define EFM_REG_MASK      8'h14
`define EFM_REG_DIAG      8'h18

// Control register fields
`define EFM_CTRL_ENC_INC  0
`define EFM_CTRL_PMON_EN  1
`define EFM_CTRL_CAM_EN   2
`define EFM_CTRL_SYNC     3

// Status and mask fields
`define EFM_ST_FRAME      0
`define EFM_ST_PULSE      1

// Diagnostic register fields
`define EFM_DIAG_CODE_LSB 0
`define EFM_DIAG_CAM      8
`define EFM_DIAG_TRACK    9
`define EFM_DIAG_SYNC     10

// Reset values
`define EFM_CTRL_RST      4'h2
`define EFM_SSI_LEN_RST   6'h19
`define EFM_SSI_HALF_RST  16'h0005
`define EFM_INCREV_RST    16'h0400

// Diagnostic codes 145 and 146
`define EFM_ERR_NONE      8'h00
`define EFM_ERR_FRAME     8'h91
`define EFM_ERR_PULSE     8'h92

// Frame length limits in bits, shortest half clock period in cycles
`define EFM_LEN_MIN       6'h02
`define EFM_LEN_MAX       6'h20
`define EFM_HALF_MIN      16'h0002

// Longest encoder monoflop time and pause between frames
`define EFM_MONO_US       30
`define EFM_MONO_CYC      (`EFM_MONO_US * `EFM_CLK_MHZ)
`define EFM_PAUSE_US      100
`define EFM_PAUSE_CYC     (`EFM_PAUSE_US * `EFM_CLK_MHZ)

`endif

// ==== hw/efm_pkg.sv ====
// Types shared by the encoder fault monitor modules.
// Plain package; no surroundings assumed.
package efm_pkg;

    typedef struct packed {
        logic [15:0] half;
        logic [5:0]  len;
    } efm_ssicfg_s;

    typedef struct packed {
        logic        done;
        logic        fault;
        logic [31:0] data;
    } efm_ssires_s;

    typedef struct packed {
        logic        fault;
        logic [31:0] count;
    } efm_incres_s;

    typedef struct packed {
        logic enc_inc;
        logic pmon_en;
        logic cam_en;
    } efm_ctrl_s;

    typedef enum logic [4:0] {
        SSI_IDLE  = 5'b00001,
        SSI_LOW   = 5'b00010,
        SSI_HIGH  = 5'b00100,
        SSI_MONO  = 5'b01000,
        SSI_PAUSE = 5'b10000
    } efm_ssi_state_e;

endpackage

// ==== hw/efm_ssi.sv ====
// Serial absolute encoder frame master with frame conformity checks.
// Assumes data pin idles high; clock driven out as a divided level.
`timescale 1ns/10ps
`include "efm_params.svh"

module efm_ssi (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    // Configuration
    input  wire efm_pkg::efm_ssicfg_s cfg_i,
    input  wire logic               enable_i,
    // Encoder pins
    input  wire logic               ssi_data_i,
    output logic                    ssi_clk_o,
    // Frame result
    output efm_pkg::efm_ssires_s    res_o
);
    import efm_pkg::*;

    typedef struct packed {
        logic [1:0]     sync;
        efm_ssi_state_e st;
        logic [15:0]    div;
        logic [5:0]     bits;
        logic [31:0]    shreg;
        logic [15:0]    mono;
        logic           sclk;
        efm_ssires_s    res;
    } efm_ssi_state_s;

    efm_ssi_state_s s_q, s_d;
    logic           din;

    assign din       = s_q.sync[1];
    assign ssi_clk_o = s_q.sclk;
    assign res_o     = s_q.res;

    always_comb begin
        s_d          = s_q;
        s_d.sync     = {s_q.sync[0], ssi_data_i};
        s_d.res.done = 1'b0;
        case (s_q.st)
            SSI_IDLE: begin
                s_d.sclk = 1'b1;
                if (enable_i) begin
                    s_d.shreg = 32'h0000_0000;
                    s_d.bits  = cfg_i.len;
                    s_d.div   = cfg_i.half;
                    s_d.mono  = 16'h0000;
                    // Bad config or line not idle: no conforming frame
                    if (cfg_i.len < `EFM_LEN_MIN || cfg_i.len > `EFM_LEN_MAX
                        || cfg_i.half < `EFM_HALF_MIN || !din) begin
                        s_d.res.done  = 1'b1;
                        s_d.res.fault = 1'b1;
                        s_d.st        = SSI_PAUSE;
                    end else begin
                        s_d.sclk = 1'b0;
                        s_d.st   = SSI_LOW;
                    end
                end
            end
            SSI_LOW: begin
                if (s_q.div <= 16'h0001) begin
                    s_d.div  = cfg_i.half;
                    s_d.sclk = 1'b1;
                    s_d.st   = SSI_HIGH;
                end else begin
                    s_d.div = s_q.div - 16'h0001;
                end
            end
            SSI_HIGH: begin
                if (s_q.div <= 16'h0001) begin
                    // Sample at end of high phase, MSB first
                    s_d.shreg = {s_q.shreg[30:0], din};
                    s_d.bits  = s_q.bits - 6'h01;
                    s_d.div   = cfg_i.half;
                    if (s_q.bits == 6'h01) begin
                        s_d.st = SSI_MONO;
                    end else begin
                        s_d.sclk = 1'b0;
                        s_d.st   = SSI_LOW;
                    end
                end else begin
                    s_d.div = s_q.div - 16'h0001;
                end
            end
            SSI_MONO: begin
                s_d.mono = s_q.mono + 16'h0001;
                // Line must be held low after last bit, then release
                if (s_q.mono == cfg_i.half && din) begin
                    s_d.res.done  = 1'b1;
                    s_d.res.fault = 1'b1;
                    s_d.st        = SSI_PAUSE;
                    s_d.mono      = 16'h0000;
                end else if (s_q.mono > cfg_i.half && din) begin
                    s_d.res.done  = 1'b1;
                    s_d.res.fault = 1'b0;
                    s_d.res.data  = s_q.shreg;
                    s_d.st        = SSI_PAUSE;
                    s_d.mono      = 16'h0000;
                end else if (s_q.mono >= 16'(`EFM_MONO_CYC)) begin
                    s_d.res.done  = 1'b1;
                    s_d.res.fault = 1'b1;
                    s_d.st        = SSI_PAUSE;
                    s_d.mono      = 16'h0000;
                end
            end
            SSI_PAUSE: begin
                s_d.sclk = 1'b1;
                s_d.mono = s_q.mono + 16'h0001;
                if (s_q.mono >= 16'(`EFM_PAUSE_CYC)) begin
                    s_d.st = SSI_IDLE;
                end
            end
            default: begin
                s_d.st = SSI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{sync: 2'b11, st: SSI_IDLE, sclk: 1'b1, default: '0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

endmodule

// ==== hw/efm_inc.sv ====
// Incremental quadrature encoder counter with missing pulse detection.
// Assumes A, B and zero marker are raw pins from outside the clock domain.
`timescale 1ns/10ps
`include "efm_params.svh"

module efm_inc (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    // Configuration
    input  wire logic [15:0]        incs_rev_i,
    input  wire logic               mon_en_i,
    // Encoder pins
    input  wire logic               inc_a_i,
    input  wire logic               inc_b_i,
    input  wire logic               inc_z_i,
    // Result
    output efm_pkg::efm_incres_s    res_o
);
    import efm_pkg::*;

    typedef struct packed {
        logic [2:0]   s1;
        logic [2:0]   s2;
        logic [2:0]   prev;
        logic         armed;
        logic [17:0]  rev;
        efm_incres_s  res;
    } efm_inc_state_s;

    efm_inc_state_s s_q, s_d;
    logic [1:0]     ab_now;
    logic [1:0]     ab_old;
    logic [17:0]    rev_abs;

    assign ab_now  = s_q.s2[1:0];
    assign ab_old  = s_q.prev[1:0];
    assign rev_abs = s_q.rev[17] ? 18'(-s_q.rev) : s_q.rev;
    assign res_o   = s_q.res;

    always_comb begin
        s_d           = s_q;
        s_d.s1        = {inc_z_i, inc_b_i, inc_a_i};
        s_d.s2        = s_q.s1;
        s_d.prev      = s_q.s2;
        s_d.res.fault = 1'b0;
        // Gray step decode: forward when new A equals old B inverted
        if (ab_now != ab_old) begin
            if ((ab_now ^ ab_old) == 2'b11) begin
                // Skipped state: at least one pulse was lost
                if (s_q.armed && mon_en_i) begin
                    s_d.res.fault = 1'b1;
                end
            end else if (ab_now[0] != ab_old[1]) begin
                s_d.res.count = s_q.res.count + 32'h0000_0001;
                s_d.rev       = s_q.rev + 18'h0_0001;
            end else begin
                s_d.res.count = s_q.res.count - 32'h0000_0001;
                s_d.rev       = s_q.rev - 18'h0_0001;
            end
        end
        // Zero marker closes one revolution
        if (s_q.s2[2] && !s_q.prev[2]) begin
            if (s_q.armed && mon_en_i
                && rev_abs < {2'b00, incs_rev_i}) begin
                s_d.res.fault = 1'b1;
            end
            s_d.rev   = 18'h0_0000;
            s_d.armed = 1'b1;
        end
        // Missing zero marker shows as an overlong revolution
        if (s_q.armed && mon_en_i
            && rev_abs > {1'b0, incs_rev_i, 1'b0}) begin
            s_d.res.fault = 1'b1;
            s_d.armed     = 1'b0;
        end
        // Partial first turn after re-enable must not report
        if (!mon_en_i) begin
            s_d.armed = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

endmodule

// ==== hw/efm_top.sv ====
// Encoder fault monitor top: Wishbone registers, fault reactions, irq.
// Assumes a classic Wishbone master on clk_i and raw encoder pins.
//
// Operation
// - A disturbed or broken serial frame reports code 145 and interrupts.
// - A frame fault stops cam processing and disables all track outputs.
// - Position holds the last good frame until the next good frame ends.
// - A pulse fault reports code 146, interrupts, stops cams and sync.
// - Counts per turn up to the zero marker short of the setting fault.
// - Pulse monitoring can be switched off and then reports nothing.
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`include "efm_params.svh"

module efm_top #(
    parameter int POS_W = 32
) (
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Absolute encoder pins
    input  wire logic              ssi_data_i,
    output logic                   ssi_clk_o,
    // Incremental encoder pins
    input  wire logic              inc_a_i,
    input  wire logic              inc_b_i,
    input  wire logic              inc_z_i,
    // Cam control and status
    output logic                   cam_run_o,
    output logic                   track_en_o,
    output logic                   sync_o,
    output logic [POS_W-1:0]       position_o,
    output logic [7:0]             diag_code_o,
    output logic                   irq_o
);
    import efm_pkg::*;

    generate
        if (POS_W < 1 || POS_W > 32) begin : g_bad_width
            $error("POS_W must lie between 1 and 32");
        end
    endgenerate

    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        efm_ctrl_s   ctrl;
        efm_ssicfg_s ssicfg;
        logic [15:0] increv;
        logic [31:0] pos_abs;
        logic [31:0] pos_out;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic [7:0]  code;
        logic        cam_run;
        logic        track_en;
        logic        sync;
        logic        irq;
    } efm_top_state_s;

    efm_top_state_s s_q, s_d;
    efm_ssires_s    ssi_res;
    efm_incres_s    inc_res;
    logic           ssi_clk;
    logic           req;
    logic           wr;
    logic [31:0]    bmask;
    logic [31:0]    ctrl_w;
    logic [31:0]    ctrl_new;
    logic [31:0]    cfg_w;
    logic [31:0]    cfg_new;
    logic           ev_frame;
    logic           ev_pulse;
    logic [1:0]     ev;
    logic [1:0]     clr;

    // Byte lanes to bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    efm_ssi u_ssi (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .cfg_i      (s_q.ssicfg),
        .enable_i   (!s_q.ctrl.enc_inc),
        .ssi_data_i (ssi_data_i),
        .ssi_clk_o  (ssi_clk),
        .res_o      (ssi_res)
    );

    efm_inc u_inc (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .incs_rev_i (s_q.increv),
        .mon_en_i   (s_q.ctrl.pmon_en && s_q.ctrl.enc_inc),
        .inc_a_i    (inc_a_i),
        .inc_b_i    (inc_b_i),
        .inc_z_i    (inc_z_i),
        .res_o      (inc_res)
    );

    assign req      = wb_cyc_i && wb_stb_i;
    assign wr       = req && wb_we_i && s_q.ack;
    assign bmask    = lane_mask(wb_sel_i);
    assign ctrl_w   = {28'h000_0000, 1'b0, s_q.ctrl.cam_en,
                       s_q.ctrl.pmon_en, s_q.ctrl.enc_inc};
    assign ctrl_new = (ctrl_w & ~bmask) | (wb_dat_i & bmask);
    assign cfg_w    = {8'h00, s_q.ssicfg.half, 2'b00, s_q.ssicfg.len};
    assign cfg_new  = (cfg_w & ~bmask) | (wb_dat_i & bmask);
    assign ev_frame = ssi_res.done && ssi_res.fault
                      && !s_q.ctrl.enc_inc;
    assign ev_pulse = inc_res.fault;
    assign ev       = {ev_pulse, ev_frame};
    assign clr      = (wr && wb_adr_i == `EFM_REG_STAT && wb_sel_i[0])
                      ? wb_dat_i[1:0] : 2'b00;

    assign wb_ack_o    = s_q.ack;
    assign wb_dat_o    = s_q.rdat;
    assign ssi_clk_o   = ssi_clk;
    assign cam_run_o   = s_q.cam_run;
    assign track_en_o  = s_q.track_en;
    assign sync_o      = s_q.sync;
    assign position_o  = s_q.pos_out[POS_W-1:0];
    assign diag_code_o = s_q.code;
    assign irq_o       = s_q.irq;

    always_comb begin
        s_d     = s_q;
        // One ack per request, dropped the cycle after
        s_d.ack = req && !s_q.ack;
        if (req && !s_q.ack) begin
            case (wb_adr_i)
                `EFM_REG_CTRL: begin
                    s_d.rdat = ctrl_w;
                end
                `EFM_REG_SSICFG: begin
                    s_d.rdat = cfg_w;
                end
                `EFM_REG_INCREV: begin
                    s_d.rdat = {16'h0000, s_q.increv};
                end
                `EFM_REG_POS: begin
                    s_d.rdat = s_q.pos_out;
                end
                `EFM_REG_STAT: begin
                    s_d.rdat = {30'h0000_0000, s_q.stat};
                end
                `EFM_REG_MASK: begin
                    s_d.rdat = {30'h0000_0000, s_q.mask};
                end
                `EFM_REG_DIAG: begin
                    s_d.rdat = {21'h00_0000, s_q.sync, s_q.track_en,
                                s_q.cam_run, s_q.code};
                end
                default: begin
                    s_d.rdat = 32'h0000_0000;
                end
            endcase
        end

        // Register writes take effect on the acked edge
        if (wr) begin
            case (wb_adr_i)
                `EFM_REG_CTRL: begin
                    s_d.ctrl.enc_inc = ctrl_new[`EFM_CTRL_ENC_INC];
                    s_d.ctrl.pmon_en = ctrl_new[`EFM_CTRL_PMON_EN];
                    s_d.ctrl.cam_en  = ctrl_new[`EFM_CTRL_CAM_EN];
                    if (ctrl_new[`EFM_CTRL_CAM_EN]) begin
                        s_d.cam_run  = 1'b1;
                        s_d.track_en = 1'b1;
                    end else begin
                        s_d.cam_run  = 1'b0;
                        s_d.track_en = 1'b0;
                    end
                    if (ctrl_new[`EFM_CTRL_SYNC]
                        && ctrl_new[`EFM_CTRL_ENC_INC]) begin
                        s_d.sync = 1'b1;
                    end
                    if (!ctrl_new[`EFM_CTRL_ENC_INC]) begin
                        s_d.sync = 1'b0;
                    end
                end
                `EFM_REG_SSICFG: begin
                    s_d.ssicfg.half = cfg_new[23:8];
                    s_d.ssicfg.len  = cfg_new[5:0];
                end
                `EFM_REG_INCREV: begin
                    s_d.increv = 16'((s_q.increv & ~bmask[15:0])
                                     | (wb_dat_i[15:0] & bmask[15:0]));
                end
                `EFM_REG_MASK: begin
                    if (wb_sel_i[0]) begin
                        s_d.mask = wb_dat_i[1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Only a correct frame replaces the held position
        if (ssi_res.done && !ssi_res.fault) begin
            s_d.pos_abs = ssi_res.data;
        end
        s_d.pos_out = s_q.ctrl.enc_inc ? inc_res.count : s_q.pos_abs;

        // Fault reactions win over a same-cycle restart
        if (ev_frame) begin
            s_d.code     = `EFM_ERR_FRAME;
            s_d.cam_run  = 1'b0;
            s_d.track_en = 1'b0;
        end
        if (ev_pulse) begin
            s_d.code     = `EFM_ERR_PULSE;
            s_d.cam_run  = 1'b0;
            s_d.track_en = 1'b0;
            s_d.sync     = 1'b0;
        end

        // Sticky status, set wins over write-one clear
        s_d.stat = (s_q.stat & ~clr) | ev;
        s_d.irq  = |(s_d.stat & s_d.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{ctrl:   3'(`EFM_CTRL_RST),
                     ssicfg: '{half: `EFM_SSI_HALF_RST,
                               len:  `EFM_SSI_LEN_RST},
                     increv: `EFM_INCREV_RST,
                     code:   `EFM_ERR_NONE,
                     default: '0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

endmodule

// ==== sim/efm_checker.sv ====
// Port checker of efm_top: bus, faults, position.
// Bound to efm_top; sees its ports only.
`timescale 1ns/10ps
`include "efm_params.svh"

module efm_checker #(
    parameter int POS_W = 32
) (
    // Clock and reset
    input wire logic             clk_i,
    input wire logic             rst_i,
    // Bus
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_ack_o,
    // Status
    input wire logic             cam_run_o,
    input wire logic             track_en_o,
    input wire logic             sync_o,
    input wire logic [POS_W-1:0] position_o,
    input wire logic [7:0]       diag_code_o,
    input wire logic             irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_frame_stop: assert property (
        $changed(diag_code_o) && diag_code_o == `EFM_ERR_FRAME
        |-> !cam_run_o && !track_en_o)
        else $error("cams run on frame fault");
    a_pos_hold: assert property (
        $changed(diag_code_o) && diag_code_o == `EFM_ERR_FRAME
        |-> $stable(position_o) [*4])
        else $error("position not held");
    a_pulse_stop: assert property (
        $changed(diag_code_o) && diag_code_o == `EFM_ERR_PULSE
        |-> !cam_run_o && !sync_o)
        else $error("pulse fault not obeyed");
    a_track_mirror: assert property (track_en_o == cam_run_o)
        else $error("track enable not cam run");
    a_code_known: assert property (
        diag_code_o inside {`EFM_ERR_NONE, `EFM_ERR_FRAME, `EFM_ERR_PULSE})
        else $error("unknown code");
    a_irq_cause: assert property (
        $rose(irq_o) |-> diag_code_o != `EFM_ERR_NONE)
        else $error("irq without code");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
endmodule

bind efm_top efm_checker #(.POS_W(POS_W)) i_efm_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cam_run_o(cam_run_o),
    .track_en_o(track_en_o), .sync_o(sync_o), .position_o(position_o),
    .diag_code_o(diag_code_o), .irq_o(irq_o)
);

// ==== sim/efm_enc_model.sv ====
// Behavioural SSI absolute encoder.
// Runs on the module clock; line idles high.
`timescale 1ns/10ps

module efm_enc_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Frame setup
    input  wire logic [15:0] half_i,
    input  wire logic [5:0]  len_i,
    input  wire logic [31:0] val_i,
    input  wire logic        brk_i,
    // Link
    input  wire logic        ssi_clk_i,
    output logic             ssi_data_o
);
    localparam int MONO = 100;
    logic        clk_q = 1'b1;
    logic        dat_q = 1'b1;
    logic [31:0] sh = 32'h0000_0000;
    int          bits = 0;
    int          cnt = 0;

    // Cut cable reads low
    assign ssi_data_o = brk_i ? 1'b0 : dat_q;

    always @(posedge clk_i) begin
        clk_q <= ssi_clk_i;
        if (rst_i) begin
            dat_q <= 1'b1;
            bits <= 0;
            cnt <= 0;
        end else if (clk_q && !ssi_clk_i && bits == 0 && cnt == 0) begin
            sh <= val_i << (32 - len_i);
        end else if (!clk_q && ssi_clk_i) begin
            dat_q <= sh[31];
            sh <= sh << 1;
            bits <= bits + 1;
            if (bits + 1 == len_i) cnt <= 1;
        end else if (cnt > 0) begin
            cnt <= cnt + 1;
            // Monoflop low, then release
            if (cnt == half_i) dat_q <= 1'b0;
            if (cnt == half_i + MONO) begin
                dat_q <= 1'b1;
                cnt <= 0;
                bits <= 0;
            end
        end
    end
endmodule

// ==== sim/tb_efm_top.sv ====
// Self-checking bench of efm_top.
// Assumes efm_enc_model on the SSI pins.
`timescale 1ns/10ps

module tb_efm_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        inc_a = 1'b0;
    logic        inc_b = 1'b0;
    logic        inc_z = 1'b0;
    logic        brk = 1'b0;
    logic [5:0]  len = 6'h19;
    logic [15:0] half = 16'h0005;
    logic [31:0] val = 32'hb832_a364;
    logic [31:0] m_pos = 32'h0000_0000;
    logic [7:0]  m_code = 8'h00;
    logic        m_cam = 1'b0;
    logic        m_syn = 1'b0;
    logic [1:0]  ph = 2'b00;
    logic        ack, sdat, sclk, cam, trk, syn, irq;
    logic [31:0] dat, pos;
    logic [7:0]  code;
    int          fails = 0;
    int          checked = 0;
    logic [7:0]  r_adr [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1c};
    logic [31:0] r_val [6] = '{32'h0000_0002, 32'h0000_0519,
                               32'h0000_0400, 32'h0, 32'h0, 32'h0};

    always #50 clk_i = ~clk_i;

    efm_top i_efm_top (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
        .ssi_data_i(sdat), .ssi_clk_o(sclk),
        .inc_a_i(inc_a), .inc_b_i(inc_b), .inc_z_i(inc_z),
        .cam_run_o(cam), .track_en_o(trk), .sync_o(syn),
        .position_o(pos), .diag_code_o(code), .irq_o(irq)
    );

    efm_enc_model i_efm_enc_model (
        .clk_i(clk_i), .rst_i(rst_i), .half_i(half), .len_i(len),
        .val_i(val), .brk_i(brk), .ssi_clk_i(sclk), .ssi_data_o(sdat)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic stop_test;
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        rdat = dat;
        cyc <= 1'b0;
        we <= 1'b0;
        if (n == 20) begin
            fails++;
            stop_test();
        end
    endtask

    task automatic waitfor(input int k, input logic [31:0] e);
        int n;
        logic [31:0] v;
        for (n = 0; n < 6000; n++) begin
            @(posedge clk_i);
            v = k == 0 ? pos : {31'h0, k == 1 ? irq : cam};
            if (v === e) break;
        end
        if (n == 6000) begin
            fails++;
            stop_test();
        end
    endtask

    task automatic status;
        logic [31:0] e;
        e = {21'h0, m_syn, m_cam, m_cam, m_code};
        wb(1'b0, 8'h18, 32'h0);
        chk("diag", rdat, e);
        chk("pins", {21'h0, syn, trk, cam, code}, e);
        chk("pos", pos, m_pos);
    endtask

    task automatic steps(input int n, input int d);
        repeat (n) begin
            @(posedge clk_i);
            ph = ph + d[1:0];
            inc_a <= ph[1] ^ ph[0];
            inc_b <= ph[1];
            m_pos = m_pos + d;
            repeat (3) @(posedge clk_i);
        end
    endtask

    task automatic mark;
        @(posedge clk_i);
        inc_z <= 1'b1;
        repeat (4) @(posedge clk_i);
        inc_z <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, r_adr[i], 32'h0);
            chk("reset", rdat, r_val[i]);
        end
        wb(1'b1, 8'h14, 32'h0000_0003);
        wb(1'b1, 8'h00, 32'h0000_0006);
        m_cam = 1'b1;
        m_pos = val & 32'h01ff_ffff;
        waitfor(0, m_pos);
        status();
        brk <= 1'b1;
        val <= lfsr(val);
        waitfor(1, 32'h1);
        m_code = 8'h91;
        m_cam = 1'b0;
        status();
        brk <= 1'b0;
        m_pos = val & 32'h01ff_ffff;
        waitfor(0, m_pos);
        status();
        wb(1'b1, 8'h10, 32'h0000_0001);
        wb(1'b0, 8'h10, 32'h0);
        chk("stat", rdat, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        // Masked fault, bad length
        wb(1'b1, 8'h14, 32'h0000_0000);
        wb(1'b1, 8'h00, 32'h0000_0006);
        wb(1'b1, 8'h04, 32'h0000_0501);
        waitfor(2, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        chk("stat", rdat, 32'h0000_0001);
        chk("irq", {31'h0, irq}, 32'h0);
        status();
        half <= 16'h0004;
        len <= 6'h0c;
        val <= lfsr(val);
        wb(1'b1, 8'h04, 32'h0000_040c);
        wb(1'b1, 8'h10, 32'h0000_0001);
        m_pos = val & 32'h0000_0fff;
        waitfor(0, m_pos);
        status();
        wb(1'b1, 8'h08, 32'h0000_0010);
        wb(1'b1, 8'h14, 32'h0000_0003);
        wb(1'b1, 8'h00, 32'h0000_000f);
        m_cam = 1'b1;
        m_syn = 1'b1;
        m_pos = 32'h0;
        mark();
        steps(16, 1);
        mark();
        steps(16, -1);
        mark();
        status();
        steps(15, 1);
        mark();
        waitfor(1, 32'h1);
        m_code = 8'h92;
        m_cam = 1'b0;
        m_syn = 1'b0;
        status();
        wb(1'b1, 8'h10, 32'h0000_0003);
        wb(1'b1, 8'h00, 32'h0000_0005);
        m_cam = 1'b1;
        mark();
        steps(3, 1);
        mark();
        wb(1'b0, 8'h10, 32'h0);
        chk("stat", rdat, 32'h0);
        status();
        stop_test();
    end
endmodule
